// ===== design/tmc_top.v
// four-channel timer mode configuration with apb register access
`timescale 1ns/100ps
`include "tmc_defines.vh"

module tmc_top (
    input wire I_REF_CLK,
    input wire I_RST,
    input wire I_PSEL,
    input wire I_PENABLE,
    input wire I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    output reg [31:0] O_PRDATA,
    output reg O_PREADY,
    output reg O_PSLVERR,
    input wire [3:0] I_PRESCALED_CLOCK,
    input wire [3:0] I_TIMER_INPUT_PIN,
    input wire [3:0] I_MASTER_IRQ,
    output reg [3:0] O_COUNT_TICK,
    output reg [3:0] O_TRIGGER,
    output reg [3:0] O_START_IRQ,
    output reg [3:0] O_RUN,
    output reg [3:0] O_HALF_WIDTH,
    output reg O_LEAD_CHANNEL,
    output reg [11:0] O_KIND,
    output reg O_IRQ
);

// ************************************************************
// register storage
// ************************************************************
reg [15:0] mode0; // channel 0 mode word
reg [15:0] mode1; // channel 1 mode word
reg [15:0] mode2; // channel 2 mode word
reg [15:0] mode3; // channel 3 mode word
reg [`TMC_STAT_W-1:0] stat; // sticky event bits
reg [`TMC_STAT_W-1:0] mask; // interrupt enables, same layout
reg [3:0] run; // channel running flags

// ************************************************************
// apb decode
// ************************************************************
wire acc; // access phase
wire wr; // write takes effect this edge
reg hit; // address maps to a register
reg [31:0] rdata; // read mux

// zero wait states: ready with every access phase
assign acc = I_PSEL & I_PENABLE;
assign wr = acc & I_PWRITE;

// read mux and address decode
always @* begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    if (I_PADDR == `TMC_OFS_MODE0) begin
        rdata = {16'h0000, mode0};
    end else if (I_PADDR == `TMC_OFS_MODE1) begin
        rdata = {16'h0000, mode1};
    end else if (I_PADDR == `TMC_OFS_MODE2) begin
        rdata = {16'h0000, mode2};
    end else if (I_PADDR == `TMC_OFS_MODE3) begin
        rdata = {16'h0000, mode3};
    end else if (I_PADDR == `TMC_OFS_START) begin
        rdata = 32'h0000_0000; // write-only strobes read as zero
    end else if (I_PADDR == `TMC_OFS_STAT) begin
        rdata = {20'h0_0000, stat};
    end else if (I_PADDR == `TMC_OFS_MASK) begin
        rdata = {20'h0_0000, mask};
    end else if (I_PADDR == `TMC_OFS_RUN) begin
        rdata = {28'h000_0000, run};
    end else begin
        hit = 1'b0; // unmapped: error answer
    end
end

// bus answer registers
always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
        O_PRDATA <= 32'h0000_0000;
        O_PREADY <= 1'b0;
        O_PSLVERR <= 1'b0;
    end else begin
        // ready answers the setup phase so the access phase completes at once
        O_PREADY <= I_PSEL & ~I_PENABLE;
        O_PSLVERR <= I_PSEL & ~I_PENABLE & ~hit;
        if (I_PSEL & ~I_PENABLE & ~I_PWRITE) begin
            O_PRDATA <= rdata;
        end
    end
end

// ************************************************************
// mode registers
// ************************************************************
wire wr_ok; // write completing to a mapped address
assign wr_ok = wr & O_PREADY & hit;

// reserved bits 13,5,4 stay zero; bit 11 only exists on channels 1-3
always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
        mode0 <= `TMC_MODE_RESET;
        mode1 <= `TMC_MODE_RESET;
        mode2 <= `TMC_MODE_RESET;
        mode3 <= `TMC_MODE_RESET;
        mask <= `TMC_STAT_RESET;
    end else if (wr_ok) begin
        if (I_PADDR == `TMC_OFS_MODE0) begin
            mode0 <= I_PWDATA[15:0] & `TMC_MODE_WMASK & 16'hF7FF;
        end else if (I_PADDR == `TMC_OFS_MODE1) begin
            mode1 <= I_PWDATA[15:0] & `TMC_MODE_WMASK;
        end else if (I_PADDR == `TMC_OFS_MODE2) begin
            mode2 <= I_PWDATA[15:0] & `TMC_MODE_WMASK;
        end else if (I_PADDR == `TMC_OFS_MODE3) begin
            mode3 <= I_PWDATA[15:0] & `TMC_MODE_WMASK;
        end else if (I_PADDR == `TMC_OFS_MASK) begin
            mask <= I_PWDATA[`TMC_STAT_W-1:0];
        end
    end
end

// software start and stop strobes: bits 3:0 start, bits 7:4 stop
wire [3:0] sw_start; // software start trigger per channel
wire [3:0] sw_stop; // software stop per channel
assign sw_start = (wr_ok && I_PADDR == `TMC_OFS_START) ? I_PWDATA[3:0] : 4'h0;
assign sw_stop = (wr_ok && I_PADDR == `TMC_OFS_START) ? I_PWDATA[7:4] : 4'h0;

// ************************************************************
// per-channel decode
// ************************************************************
wire [63:0] mode_all; // four mode words side by side
assign mode_all = {mode3, mode2, mode1, mode0};

wire [3:0] edge_tick; // valid pin edge per channel
wire [3:0] hw_trig; // hardware trigger per channel
wire [3:0] legal; // configuration allowed
wire [3:0] st_irq; // mode interrupts at count start
wire [3:0] retrig; // retrigger honoured while running
wire [11:0] kind; // mode kind per channel
wire [3:0] base_clk; // channel base clock per channel
wire [3:0] trig; // combined start trigger per channel
wire [3:0] start_ok; // start accepted this cycle
wire [3:0] bad_cfg; // start attempted on prohibited setting

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : chan
        wire [15:0] m; // this channel's mode word
        assign m = mode_all[16*g+15:16*g];

        tmc_edge_detect u_edge (
            .i_clk(I_REF_CLK),
            .i_rst(I_RST),
            .i_pin(I_TIMER_INPUT_PIN[g]),
            .i_edge_sel(m[`TMC_CIS_HI:`TMC_CIS_LO]),
            .i_trig_sel(m[`TMC_STS_HI:`TMC_STS_LO]),
            .i_master_irq(I_MASTER_IRQ[g]),
            .o_count_edge(edge_tick[g]),
            .o_hw_trig(hw_trig[g])
        );

        tmc_mode_decode u_mode (
            .i_mode(m[`TMC_MD_HI:`TMC_MD_LO]),
            .i_trig_sel(m[`TMC_STS_HI:`TMC_STS_LO]),
            .o_kind(kind[3*g+2:3*g]),
            .o_start_irq(st_irq[g]),
            .o_retrig(retrig[g]),
            .o_legal(legal[g])
        );

        // code order 00,01,10,11 maps to prescaled clocks 0,2,1,3
        assign base_clk[g] =
            (m[`TMC_CKS_HI:`TMC_CKS_LO] == 2'b00) ? I_PRESCALED_CLOCK[0] :
            (m[`TMC_CKS_HI:`TMC_CKS_LO] == 2'b01) ? I_PRESCALED_CLOCK[2] :
            (m[`TMC_CKS_HI:`TMC_CKS_LO] == 2'b10) ? I_PRESCALED_CLOCK[1] :
            I_PRESCALED_CLOCK[3];

        // software start always valid; hardware per trigger select
        assign trig[g] = sw_start[g] | hw_trig[g];

        // once running, one-count kinds retrigger only when allowed
        assign start_ok[g] = trig[g] & legal[g] &
            (~run[g] | (kind[3*g+2:3*g] == 3'd3 & retrig[g]));
        assign bad_cfg[g] = trig[g] & ~legal[g];
    end
endgenerate

// ************************************************************
// run flags and registered channel outputs
// ************************************************************
// a prohibited code keeps the channel stopped; stop strobe wins over start
always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
        run <= 4'h0;
        O_COUNT_TICK <= 4'h0;
        O_TRIGGER <= 4'h0;
        O_START_IRQ <= 4'h0;
        O_RUN <= 4'h0;
        O_HALF_WIDTH <= 4'h0;
        O_LEAD_CHANNEL <= 1'b0;
        O_KIND <= 12'h000;
    end else begin
        run <= (run | start_ok) & ~sw_stop & legal;
        // count clock: base clock or pin valid edges
        O_COUNT_TICK <= {mode3[`TMC_CCS_BIT] ? edge_tick[3] : base_clk[3],
                         mode2[`TMC_CCS_BIT] ? edge_tick[2] : base_clk[2],
                         mode1[`TMC_CCS_BIT] ? edge_tick[1] : base_clk[1],
                         mode0[`TMC_CCS_BIT] ? edge_tick[0] : base_clk[0]};
        O_TRIGGER <= start_ok;
        // interrupt at count start only for modes that ask for it
        O_START_IRQ <= start_ok & ~run & st_irq;
        O_RUN <= (run | start_ok) & ~sw_stop & legal;
        // bit 11 is the half-width select on channels 1 and 3 only
        O_HALF_WIDTH <= {mode3[`TMC_B11_BIT], 1'b0, mode1[`TMC_B11_BIT], 1'b0};
        O_LEAD_CHANNEL <= mode2[`TMC_B11_BIT];
        O_KIND <= kind;
    end
end

// ************************************************************
// sticky status and interrupt
// ************************************************************
wire [`TMC_STAT_W-1:0] events; // this cycle's events
wire [`TMC_STAT_W-1:0] clr; // write-one-to-clear bits
assign events = {bad_cfg, start_ok, start_ok & ~run & st_irq};
assign clr = (wr_ok && I_PADDR == `TMC_OFS_STAT) ? I_PWDATA[`TMC_STAT_W-1:0]
                                                 : `TMC_STAT_RESET;

// a new event beats a clear landing in the same cycle
always @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
        stat <= `TMC_STAT_RESET;
        O_IRQ <= 1'b0;
    end else begin
        stat <= (stat & ~clr) | events;
        O_IRQ <= |(((stat & ~clr) | events) & mask);
    end
end

endmodule

// ===== design/tmc_defines.vh
// register map, field positions, codes and reset values of the timer channel mode block
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define TMC_OFS_MODE0 12'h000
`define TMC_OFS_MODE1 12'h004
`define TMC_OFS_MODE2 12'h008
`define TMC_OFS_MODE3 12'h00C
`define TMC_OFS_START 12'h010
`define TMC_OFS_STAT 12'h014
`define TMC_OFS_MASK 12'h018
`define TMC_OFS_RUN 12'h01C

// ************************************************************
// mode register fields
// ************************************************************
`define TMC_CKS_HI 15
`define TMC_CKS_LO 14
`define TMC_CCS_BIT 12
`define TMC_B11_BIT 11
`define TMC_STS_HI 10
`define TMC_STS_LO 8
`define TMC_CIS_HI 7
`define TMC_CIS_LO 6
`define TMC_MD_HI 3
`define TMC_MD_LO 0
`define TMC_MODE_WMASK 16'hDFCF
`define TMC_MODE_RESET 16'h0000

// ************************************************************
// codes
// ************************************************************
`define TMC_STS_SW 3'b000
`define TMC_STS_EDGE 3'b001
`define TMC_STS_BOTH 3'b010
`define TMC_STS_MASTER 3'b100
`define TMC_CIS_FALL 2'b00
`define TMC_CIS_RISE 2'b01
`define TMC_CIS_LOW 2'b10
`define TMC_CIS_HIGH 2'b11
`define TMC_MD_INT0 4'b0000
`define TMC_MD_INT1 4'b0001
`define TMC_MD_CAP0 4'b0100
`define TMC_MD_CAP1 4'b0101
`define TMC_MD_EVT 4'b0110
`define TMC_MD_ONE0 4'b1000
`define TMC_MD_ONE1 4'b1001
`define TMC_MD_CAPONE 4'b1100

// ************************************************************
// status bit layout: [3:0] start irq, [7:4] trigger, [11:8] bad config
// ************************************************************
`define TMC_STAT_W 12
`define TMC_STAT_RESET 12'h000

`endif

// ===== design/tmc_edge_detect.v
// valid edge and trigger decode for one timer channel
`timescale 1ns/100ps
`include "tmc_defines.vh"

module tmc_edge_detect (
    input wire i_clk,
    input wire i_rst,
    input wire i_pin,
    input wire [1:0] i_edge_sel,
    input wire [2:0] i_trig_sel,
    input wire i_master_irq,
    output reg o_count_edge,
    output reg o_hw_trig
);

// ************************************************************
// pin history
// ************************************************************
reg pin_q; // pin one cycle ago
wire rise; // rising edge seen
wire fall; // falling edge seen
reg valid_edge; // edge chosen by edge select

assign rise = i_pin & ~pin_q;
assign fall = ~i_pin & pin_q;

// the valid edge selected for counting and for trigger 001
always @* begin
    case (i_edge_sel)
        `TMC_CIS_FALL: valid_edge = fall;
        `TMC_CIS_RISE: valid_edge = rise;
        // width measurement: both edges are valid
        default: valid_edge = rise | fall;
    endcase
end

// register edge and trigger so both outputs come from flip-flops
always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        pin_q <= 1'b0;
        o_count_edge <= 1'b0;
        o_hw_trig <= 1'b0;
    end else begin
        pin_q <= i_pin;
        o_count_edge <= valid_edge;
        case (i_trig_sel)
            `TMC_STS_EDGE: o_hw_trig <= valid_edge;
            `TMC_STS_BOTH: o_hw_trig <= rise | fall;
            `TMC_STS_MASTER: o_hw_trig <= i_master_irq;
            // software only or prohibited: hardware ignored
            default: o_hw_trig <= 1'b0;
        endcase
    end
end

endmodule

// ===== design/tmc_mode_decode.v
// operation mode decode for one timer channel
`timescale 1ns/100ps
`include "tmc_defines.vh"

module tmc_mode_decode (
    input wire [3:0] i_mode,
    input wire [2:0] i_trig_sel,
    output reg [2:0] o_kind,
    output reg o_start_irq,
    output reg o_retrig,
    output reg o_legal
);

// kind: 0 interval, 1 capture, 2 event, 3 one-count, 4 capture+one-count
always @* begin
    o_kind = 3'd0;
    o_start_irq = 1'b0;
    o_retrig = 1'b0;
    o_legal = 1'b1;
    case (i_mode)
        `TMC_MD_INT0: o_kind = 3'd0;
        `TMC_MD_INT1: begin
            o_kind = 3'd0;
            o_start_irq = 1'b1;
        end
        `TMC_MD_CAP0: o_kind = 3'd1;
        `TMC_MD_CAP1: begin
            o_kind = 3'd1;
            o_start_irq = 1'b1;
        end
        `TMC_MD_EVT: o_kind = 3'd2;
        `TMC_MD_ONE0: o_kind = 3'd3;
        `TMC_MD_ONE1: begin
            o_kind = 3'd3;
            o_retrig = 1'b1;
        end
        `TMC_MD_CAPONE: o_kind = 3'd4;
        default: o_legal = 1'b0;
    endcase
    // unlisted trigger codes are prohibited
    if (i_trig_sel != `TMC_STS_SW && i_trig_sel != `TMC_STS_EDGE &&
        i_trig_sel != `TMC_STS_BOTH && i_trig_sel != `TMC_STS_MASTER) begin
        o_legal = 1'b0;
    end
end

endmodule

// ===== verification/tmc_top_sva.sv
// port-level checks of the timer channel mode block
`timescale 1ns/100ps
`include "tmc_defines.vh"
module tmc_top_sva (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic [3:0] I_PRESCALED_CLOCK,
    input wire logic [3:0] I_TIMER_INPUT_PIN,
    input wire logic [3:0] O_COUNT_TICK,
    input wire logic [3:0] O_TRIGGER,
    input wire logic [3:0] O_START_IRQ,
    input wire logic [3:0] O_RUN,
    input wire logic [3:0] O_HALF_WIDTH,
    input wire logic O_LEAD_CHANNEL,
    input wire logic [11:0] O_KIND
);
    // ****************
    // shadow of the mode registers
    // ****************
    logic [15:0] m [4]; // what software wrote, reserved bits dropped
    wire wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && (I_PADDR < `TMC_OFS_START);
    // codes 01 and 10 cross over, so the index is the field reversed
    wire pc0 = I_PRESCALED_CLOCK[{m[0][14], m[0][15]}];
    wire [3:0] k0 = kd(m[0]); // bit 3 flags a legal setting
    // shadow commits at the access edge, as the register does
    always @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            m <= '{default: 16'h0000};
        end else if (wr) begin
            m[I_PADDR[3:2]] <= I_PWDATA[15:0] & `TMC_MODE_WMASK;
        end
    end
    // expected kind of a mode value
    function automatic logic [3:0] kd(input logic [15:0] r);
        case (r[3:0])
            4'h0, 4'h1: kd = 4'h8;
            4'h4, 4'h5: kd = 4'h9;
            4'h6: kd = 4'hA;
            4'h8, 4'h9: kd = 4'hB;
            4'hC: kd = 4'hC;
            default: kd = 4'h0;
        endcase
        if (!(r[10:8] inside {3'h0, 3'h1, 3'h2, 3'h4})) kd = 4'h0;
    endfunction
    // ****************
    // properties
    // ****************
    default clocking dc @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    sequence s_setup; I_PSEL && !I_PENABLE; endsequence
    sequence s_beat; O_PREADY ##1 !O_PREADY; endsequence
    AST_READY: assert property (s_setup |=> s_beat)
        else $error("ready is not one beat after setup");
    AST_SLVERR: assert property (O_PREADY || O_PSLVERR |->
        O_PREADY && (O_PSLVERR == (I_PADDR > `TMC_OFS_RUN))) else $error("bad error flag");
    AST_HALF: assert property ($stable(m[1]) && $stable(m[3]) |->
        O_HALF_WIDTH == {m[3][11], 1'b0, m[1][11], 1'b0}) else $error("bad half width");
    AST_LEAD: assert property ($stable(m[2]) |->
        O_LEAD_CHANNEL == m[2][11]) else $error("bad lead flag");
    AST_KIND: assert property ($stable(m[0]) && k0[3] |->
        O_KIND[2:0] == k0[2:0]) else $error("bad kind");
    // the edge that releases reset still loads zero, so skip it and the next one
    AST_TICK_CLK: assert property (!$past(I_RST) && !m[0][12] |=>
        O_COUNT_TICK[0] == $past(pc0)) else $error("tick is not the chosen clock");
    AST_TICK_EDGE: assert property (m[0][12] && m[0][7:6] == 2'h1 &&
        $rose(I_TIMER_INPUT_PIN[0]) |-> ##[1:3] O_COUNT_TICK[0]) else $error("no edge tick");
    AST_PIN_TRIG: assert property (m[0][10:6] == 5'h05 && m[0][3:0] == 4'h9 &&
        $rose(I_TIMER_INPUT_PIN[0]) |-> ##[1:3] O_TRIGGER[0]) else $error("edge not taken");
    AST_START_IRQ: assert property (O_START_IRQ[0] |-> O_TRIGGER[0] &&
        O_RUN[0] && m[0][3:0] inside {4'h1, 4'h5}) else $error("stray start interrupt");
    AST_NO_RETRIG: assert property (O_TRIGGER[0] && m[0][3:0] inside {4'h8, 4'hC}
        |-> !$past(O_RUN[0])) else $error("retrigger taken");
endmodule

// ===== verification/tmc_pin_model.sv
// pins, prescaled clocks and master interrupts around the timer block
`timescale 1ns/100ps
module tmc_pin_model (
    input wire logic i_clk,
    output logic [3:0] o_pclk,
    output logic [3:0] o_pin = 4'h0,
    output logic [3:0] o_mirq = 4'h0
);
    logic [3:0] div = 4'h0; // free divider, four distinct rates
    always @(posedge i_clk) begin
        div <= div + 4'h1;
    end
    assign o_pclk = div;
    // pin moves just after an edge and then holds
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge i_clk);
        o_pin[ch] <= lvl;
    endtask
    // one-cycle master interrupt pulse
    task automatic pulse_irq(input int ch);
        @(posedge i_clk);
        o_mirq[ch] <= 1'b1;
        @(posedge i_clk);
        o_mirq[ch] <= 1'b0;
    endtask
endmodule

// ===== verification/test_timer_channel_mode_config.sv
// self-checking bench for the timer channel mode block
`timescale 1ns/100ps
`include "tmc_defines.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin num_errors++; \
    $display("wrong value at %0t: %h expected %h", $time, g, x); end end
module test_timer_channel_mode_config;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rq; // last read data
    logic re; // last error flag
    wire [31:0] prdata;
    wire pready, pslverr, lead, irq;
    wire [3:0] pclk, pin, mirq, tick, trig, sirq, run, half;
    wire [11:0] kind;
    int num_errors = 0;
    int n_tests = 0;
    int tc = 0; // channel 0 trigger pulses
    int ic = 0; // channel 0 start interrupt pulses
    int b, c;
    logic [3:0] mds [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hC};
    logic [2:0] kds [8] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4};
    // trigger code, edge code, {rise, fall} counts
    logic [2:0] sts [6] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2};
    logic [1:0] input_edge_select [6] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    logic [1:0] exs [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
    always #10 clk = ~clk;
    // pulse counters, one-cycle outputs are caught at every edge
    always @(posedge clk) begin
        tc <= tc + int'(trig[0]);
        ic <= ic + int'(sirq[0]);
    end
    tmc_top u_tmc_top (.I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_PRESCALED_CLOCK(pclk),
        .I_TIMER_INPUT_PIN(pin), .I_MASTER_IRQ(mirq), .O_COUNT_TICK(tick), .O_TRIGGER(trig),
        .O_START_IRQ(sirq), .O_RUN(run), .O_HALF_WIDTH(half), .O_LEAD_CHANNEL(lead),
        .O_KIND(kind), .O_IRQ(irq));
    tmc_pin_model u_tmc_pin_model (.i_clk(clk), .o_pclk(pclk), .o_pin(pin), .o_mirq(mirq));
    // ****************
    // bus access and verdict
    // ****************
    // one apb transfer, held until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic conclude();
        $display("errors %0d of %0d comparisons", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // reset values, reserved bits, width and lead flags
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0000_0000);
            `CHK(rq, 32'h0000_0000)
            apb(1'b1, 12'(4 * i), 32'hFFFF_FFFF);
            apb(1'b0, 12'(4 * i), 32'h0000_0000);
            `CHK(rq, (i == 0) ? 32'h0000_D7CF : 32'h0000_DFCF)
        end
        repeat (2) @(posedge clk);
        `CHK({half, lead}, 5'h15)
        for (int i = 0; i < 4; i++) apb(1'b1, 12'(4 * i), 32'h0000_0000);
        repeat (2) @(posedge clk);
        `CHK({half, lead}, 5'h00)
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        apb(1'b0, 12'h020, 32'h0000_0000);
        `CHK({re, rq}, {1'b1, 32'h0000_0000})
        // every clock source code, the checker follows the tick
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `TMC_OFS_MODE0, {16'h0000, 2'(i), 14'h0000});
            repeat (8) @(posedge clk);
        end
        // every mode: kind, start interrupt, retrigger, stop
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `TMC_OFS_MODE0, {28'h000_0000, mds[i]});
            b = tc;
            c = ic;
            repeat (2) apb(1'b1, `TMC_OFS_START, 32'h0000_0001);
            repeat (3) @(posedge clk);
            `CHK({run[0], kind[2:0]}, {1'b1, kds[i]})
            `CHK(ic - c, int'(mds[i] == 4'h1 || mds[i] == 4'h5))
            `CHK(tc - b, (mds[i] == 4'h9) ? 2 : 1)
            apb(1'b1, `TMC_OFS_START, 32'h0000_0010);
            repeat (3) @(posedge clk);
            `CHK(run[0], 1'b0)
        end
        // interrupt: raised while masked out, let through, cleared
        apb(1'b1, `TMC_OFS_STAT, 32'h0000_0FFF);
        apb(1'b1, `TMC_OFS_MODE0, 32'h0000_0001);
        apb(1'b1, `TMC_OFS_START, 32'h0000_0001);
        repeat (4) @(posedge clk);
        `CHK(irq, 1'b0)
        apb(1'b0, `TMC_OFS_STAT, 32'h0000_0000);
        `CHK(rq, 32'h0000_0011)
        apb(1'b1, `TMC_OFS_MASK, 32'h0000_0001);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        apb(1'b1, `TMC_OFS_STAT, 32'h0000_0001);
        repeat (3) @(posedge clk);
        apb(1'b0, `TMC_OFS_STAT, 32'h0000_0000);
        `CHK({irq, rq}, {1'b0, 32'h0000_0010})
        apb(1'b1, `TMC_OFS_START, 32'h0000_0010);
        // pin trigger codes and edge codes, pin counts the tick
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `TMC_OFS_MODE0, {20'h0_0001, 1'b0, sts[i], input_edge_select[i], 2'b00, 4'h9});
            b = tc;
            u_tmc_pin_model.set_pin(0, 1'b1);
            repeat (4) @(posedge clk);
            `CHK(tc - b, int'(exs[i][1]))
            u_tmc_pin_model.set_pin(0, 1'b0);
            repeat (4) @(posedge clk);
            `CHK(tc - b, int'(exs[i][1]) + int'(exs[i][0]))
            apb(1'b1, `TMC_OFS_START, 32'h0000_0010);
        end
        // master interrupt as trigger, then a prohibited trigger code
        apb(1'b1, `TMC_OFS_MODE0, 32'h0000_0409);
        b = tc;
        u_tmc_pin_model.pulse_irq(0);
        repeat (4) @(posedge clk);
        `CHK(tc - b, 1)
        apb(1'b1, `TMC_OFS_START, 32'h0000_0010);
        apb(1'b1, `TMC_OFS_STAT, 32'h0000_0FFF);
        apb(1'b1, `TMC_OFS_MODE0, 32'h0000_0300);
        apb(1'b1, `TMC_OFS_START, 32'h0000_0001);
        repeat (3) @(posedge clk);
        apb(1'b0, `TMC_OFS_STAT, 32'h0000_0000);
        `CHK({run[0], rq[8]}, 2'b01)
        conclude();
    end
endmodule
bind tmc_top tmc_top_sva u_tmc_top_sva (.I_REF_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE,
    .I_PADDR, .I_PWDATA, .O_PREADY, .O_PSLVERR, .I_PRESCALED_CLOCK, .I_TIMER_INPUT_PIN,
    .O_COUNT_TICK, .O_TRIGGER, .O_START_IRQ, .O_RUN, .O_HALF_WIDTH, .O_LEAD_CHANNEL, .O_KIND);
